// ---- rtl/ptmr_paired_timer.sv ----
// Pair of 16-bit timers that run alone or chain into one 32-bit timer or counter.
// Assumes one clock whose enabled edges are instruction cycles, and pins from outside the domain.
// Operation
// - Each half is timer or synchronous counter
// - Low word least, high word most significant
// - Chained mode uses low control and inputs
// - Chained interrupt uses high flag and enable
// - Only low prescaler output gets sync stage
// - Chained timer counts to combined period, wraps
// - Reading low word latches high into holding
// - Chained: holding then low write loads both words
// - Chained counter counts synced external edges
// - Idle stops counting when idle-stop set
// - Gated mode counts cycles while gate high
// - Both timers gate; high one only when unchained
// - Gate falling edge stops, keeps count
// - High timer emits converter trigger on match
// - Prescaler divides by 1, 8, 64, 256
// - Chained mode ignores high prescaler
// - Count or control writes clear prescaler
// - Disabled low timer keeps its prescaler
// - Control write leaves count unchanged
// - Sleep stops all counting
// - Single timer counts to period, wraps
`timescale 1ns/1ps
`include "ptmr_regs.svh"

module ptmr_paired_timer
  import ptmr_pkg::*;
(
  // Clock, reset and enable
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        clkEn,
  // CPU power states
  input  wire logic        cpuIdle,
  input  wire logic        cpuSleep,
  // External clock or gate pins
  input  wire logic        gateClockInput,
  input  wire logic        highClockInput,
  // Software write strobes and data
  input  wire logic [15:0] wrData,
  input  wire logic        wrLowCount,
  input  wire logic        wrHighCount,
  input  wire logic        wrHolding,
  input  wire logic        wrPeriodLow,
  input  wire logic        wrPeriodHigh,
  input  wire logic        wrLowCtrl,
  input  wire logic        wrHighCtrl,
  // Software read notice
  input  wire logic        rdLowCount,
  // Interrupt enables and flag clears
  input  wire logic        lowIntEnable,
  input  wire logic        highTimerIntEnable,
  input  wire logic        clrLowIntFlag,
  input  wire logic        clrHighIntFlag,
  // Register contents
  output logic      [15:0] lowCountWord,
  output logic      [15:0] highCountWord,
  output logic      [15:0] highWordHolding,
  output logic      [15:0] periodLow,
  output logic      [15:0] periodHigh,
  output logic      [15:0] lowTimerControl,
  output logic      [15:0] highTimerControl,
  // Flags, interrupt requests, trigger
  output logic             lowIntFlag,
  output logic             highTimerIntFlag,
  output logic             lowIntReq,
  output logic             highIntReq,
  output logic             adcTrigger
);

  import ptmr_pkg::*;

  // ****************************************
  // State and intermediate terms
  // ****************************************
  ptmr_state_t s_q;
  ptmr_state_t s_d;

  logic        mode32;
  logic        lowOn;
  logic        highOn;
  logic        lowRun;
  logic        highRun;
  logic        lowSrc;
  logic        highSrc;
  logic        lowPulse;
  logic        highPulse;
  logic        lowTick;
  logic        highTick;
  logic        gateLvl;
  logic        gateRise;
  logic        gateFall;
  logic        highLvl;
  logic        highRise;
  logic        lowGated;
  logic        highGated;
  logic [31:0] count32;
  logic [31:0] period32;

  // Prescaler terminal count for a selection
  function automatic logic [7:0] preTerm(input logic [1:0] sel);
    logic [7:0] t;
    t = `PTMR_PRE_TERM_DIV1;
    case (ptmr_presc_t'(sel))
      PTMR_DIV1:   t = `PTMR_PRE_TERM_DIV1;
      PTMR_DIV8:   t = `PTMR_PRE_TERM_DIV8;
      PTMR_DIV64:  t = `PTMR_PRE_TERM_DIV64;
      PTMR_DIV256: t = `PTMR_PRE_TERM_DIV256;
      default:     t = `PTMR_PRE_TERM_DIV1;
    endcase
    return t;
  endfunction : preTerm

  // ****************************************
  // Timing and limitations
  // ****************************************
  // Each enabled clock edge stands for one instruction cycle.
  // Internal source: the low count first steps two edges after enable.
  // That extra edge is the sync stage behind the low prescaler.
  // The high timer in single mode steps one edge earlier than the low one.
  // Pin edges take two edges to cross the synchroniser.
  // One more edge passes before a rise or fall is seen.
  // Pins slower than half the clock are counted faithfully.
  // Faster pin pulses are lost, the price of sampling them.
  // Prescaler compare uses >= so a smaller divide ends at once.
  // Without it a shrunk divide would wrap through 256 counts first.
  // Software writes win over counting in the same cycle.
  // A clear strobe and a match in one cycle leave the flag set.
  // So no event is ever lost to a late clear.
  // Chained mode steps both words together as one count.
  // The high control word keeps its value but drives nothing meanwhile.
  // The low prescaler clears only when the low timer was already on.
  // This mirrors a prescaler whose clock stops while the timer is off.
  // A frozen clock enable stretches the trigger pulse.
  // The trigger is state like everything else, so it freezes too.
  // The low request is held off while chained.
  // Only the high flag and enable speak for the combined timer.

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d       = s_q;
    lowPulse  = 1'b0;
    highPulse = 1'b0;
    // Chaining bit lives only in the low control word
    mode32    = s_q.lowCtrl[`PTMR_CTRL_MODE32];
    lowOn     = s_q.lowCtrl[`PTMR_CTRL_TIMER_ON];
    highOn    = s_q.highCtrl[`PTMR_CTRL_TIMER_ON] && !mode32;
    // Pins: second stage and its delayed copy only, never the first flop
    gateLvl   = s_q.gateSync[1];
    gateRise  = s_q.gateSync[1] && !s_q.gateDly;
    gateFall  = !s_q.gateSync[1] && s_q.gateDly;
    highLvl   = s_q.highSync[1];
    highRise  = s_q.highSync[1] && !s_q.highDly;
    // Gated accumulation needs the internal source selected
    lowGated  = s_q.lowCtrl[`PTMR_CTRL_GATE_ACCUM] && !s_q.lowCtrl[`PTMR_CTRL_CLK_SEL];
    // High gate bit is dead while chained
    highGated = s_q.highCtrl[`PTMR_CTRL_GATE_ACCUM] && !s_q.highCtrl[`PTMR_CTRL_CLK_SEL] && !mode32;
    // Sleep halts everything; idle halts only when idle-stop is set
    lowRun    = lowOn && !cpuSleep && !(cpuIdle && s_q.lowCtrl[`PTMR_CTRL_IDLE_STOP]);
    highRun   = highOn && !cpuSleep && !(cpuIdle && s_q.highCtrl[`PTMR_CTRL_IDLE_STOP]);
    // External edges are always synchronised, so no asynchronous counter exists
    lowSrc    = s_q.lowCtrl[`PTMR_CTRL_CLK_SEL] ? gateRise : (lowGated ? gateLvl : 1'b1);
    highSrc   = s_q.highCtrl[`PTMR_CTRL_CLK_SEL] ? highRise : (highGated ? highLvl : 1'b1);
    lowTick   = s_q.lowTickSync;
    highTick  = 1'b0;
    count32   = {s_q.highCount, s_q.lowCount};
    period32  = {s_q.periodHigh, s_q.periodLow};

    if (clkEn) begin
      // Two-flop synchronisers on both pins
      s_d.gateSync = {s_q.gateSync[0], gateClockInput};
      s_d.highSync = {s_q.highSync[0], highClockInput};
      s_d.gateDly  = s_q.gateSync[1];
      s_d.highDly  = s_q.highSync[1];
      s_d.adcTrig  = 1'b0;

      // Low prescaler; its clock stops with the timer, so it holds its value
      if (lowRun && lowSrc) begin
        if (s_q.preLow >= preTerm(s_q.lowCtrl[`PTMR_CTRL_PRESC_HI:`PTMR_CTRL_PRESC_LO])) begin
          s_d.preLow = 8'h00;
          lowPulse   = 1'b1;
        end else begin
          s_d.preLow = 8'(s_q.preLow + 8'h01);
        end
      end
      // Extra stage costs a cycle of latency; fast external pin pulses are still lost
      s_d.lowTickSync = lowPulse;

      // High prescaler has no such stage and is unused while chained
      if (highRun && highSrc) begin
        if (s_q.preHigh >= preTerm(s_q.highCtrl[`PTMR_CTRL_PRESC_HI:`PTMR_CTRL_PRESC_LO])) begin
          s_d.preHigh = 8'h00;
          highPulse   = 1'b1;
        end else begin
          s_d.preHigh = 8'(s_q.preHigh + 8'h01);
        end
      end
      highTick = highPulse;

      // Flag clears first so a same-cycle event still sets the flag
      if (clrLowIntFlag) begin
        s_d.lowFlag = 1'b0;
      end
      if (clrHighIntFlag) begin
        s_d.highFlag = 1'b0;
      end

      if (mode32) begin
        // Chained: one 32-bit count stepped by the low tick
        if (lowTick) begin
          if (count32 == period32) begin
            s_d.lowCount  = 16'h0000;
            s_d.highCount = 16'h0000;
            s_d.highFlag  = 1'b1;
            s_d.adcTrig   = 1'b1;
          end else begin
            {s_d.highCount, s_d.lowCount} = 32'(count32 + 32'h0000_0001);
          end
        end
        // End of accumulation: stop and flag, count kept
        if (lowGated && lowOn && gateFall) begin
          s_d.highFlag = 1'b1;
        end
      end else begin
        // Independent low timer
        if (lowTick) begin
          if (s_q.lowCount == s_q.periodLow) begin
            s_d.lowCount = 16'h0000;
            s_d.lowFlag  = 1'b1;
          end else begin
            s_d.lowCount = 16'(s_q.lowCount + 16'h0001);
          end
        end
        // Independent high timer
        if (highTick) begin
          if (s_q.highCount == s_q.periodHigh) begin
            s_d.highCount = 16'h0000;
            s_d.highFlag  = 1'b1;
            s_d.adcTrig   = 1'b1;
          end else begin
            s_d.highCount = 16'(s_q.highCount + 16'h0001);
          end
        end
        // Gate falls end each accumulation without clearing
        if (lowGated && lowOn && gateFall) begin
          s_d.lowFlag = 1'b1;
        end
        if (highGated && highOn && !highLvl && s_q.highDly) begin
          s_d.highFlag = 1'b1;
        end
      end

      // Coherent read: capture the high word as it stood when low was read
      if (rdLowCount) begin
        s_d.holding = s_q.highCount;
      end

      // Software writes override counting in the same cycle
      if (wrHolding) begin
        s_d.holding = wrData;
      end
      if (wrLowCount) begin
        s_d.lowCount = wrData;
        if (mode32) begin
          s_d.highCount = s_q.holding;
        end
        if (lowOn) begin
          s_d.preLow = 8'h00;
        end
      end
      if (wrHighCount) begin
        s_d.highCount = wrData;
        s_d.preHigh   = 8'h00;
        if (mode32 && lowOn) begin
          s_d.preLow = 8'h00;
        end
      end
      if (wrPeriodLow) begin
        s_d.periodLow = wrData;
      end
      if (wrPeriodHigh) begin
        s_d.periodHigh = wrData;
      end
      // Control writes touch the prescaler, never the count
      if (wrLowCtrl) begin
        s_d.lowCtrl = wrData & `PTMR_LOW_CTRL_MASK;
        if (lowOn) begin
          s_d.preLow = 8'h00;
        end
      end
      if (wrHighCtrl) begin
        s_d.highCtrl = wrData & `PTMR_HIGH_CTRL_MASK;
        s_d.preHigh  = 8'h00;
      end

      // Requests: low request is idle while chained
      s_d.lowIrq  = s_d.lowFlag && lowIntEnable && !mode32;
      s_d.highIrq = s_d.highFlag && highTimerIntEnable;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q             <= '0;
      s_q.lowCount    <= `PTMR_COUNT_RESET;
      s_q.highCount   <= `PTMR_COUNT_RESET;
      s_q.periodLow   <= `PTMR_PERIOD_RESET;
      s_q.periodHigh  <= `PTMR_PERIOD_RESET;
      s_q.lowCtrl     <= `PTMR_CTRL_RESET;
      s_q.highCtrl    <= `PTMR_CTRL_RESET;
      s_q.preLow      <= 8'h00;
      s_q.preHigh     <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs straight from the state register
  // ****************************************
  assign lowCountWord     = s_q.lowCount;
  assign highCountWord    = s_q.highCount;
  assign highWordHolding  = s_q.holding;
  assign periodLow        = s_q.periodLow;
  assign periodHigh       = s_q.periodHigh;
  assign lowTimerControl  = s_q.lowCtrl;
  assign highTimerControl = s_q.highCtrl;
  assign lowIntFlag       = s_q.lowFlag;
  assign highTimerIntFlag = s_q.highFlag;
  assign lowIntReq        = s_q.lowIrq;
  assign highIntReq       = s_q.highIrq;
  assign adcTrigger       = s_q.adcTrig;

endmodule : ptmr_paired_timer

// ---- shared/ptmr_regs.svh ----
// Constants of the paired timer: control field positions, reset values and prescaler counts.
// Assumes inclusion by the package and the timer module only.
`ifndef PTMR_REGS_SVH
`define PTMR_REGS_SVH

// ****************************************
// Control word field positions
// ****************************************
`define PTMR_CTRL_TIMER_ON    15
`define PTMR_CTRL_IDLE_STOP   13
`define PTMR_CTRL_GATE_ACCUM  6
`define PTMR_CTRL_PRESC_HI    5
`define PTMR_CTRL_PRESC_LO    4
`define PTMR_CTRL_MODE32      3
`define PTMR_CTRL_CLK_SEL     1

// Writable bits; the high control word has no chaining bit
`define PTMR_LOW_CTRL_MASK    16'ha07a
`define PTMR_HIGH_CTRL_MASK   16'ha072

// ****************************************
// Reset values
// ****************************************
`define PTMR_CTRL_RESET       16'h0000
`define PTMR_PERIOD_RESET     16'hffff
`define PTMR_COUNT_RESET      16'h0000

// ****************************************
// Prescaler terminal counts (divide minus one)
// ****************************************
`define PTMR_PRE_TERM_DIV1    8'h00
`define PTMR_PRE_TERM_DIV8    8'h07
`define PTMR_PRE_TERM_DIV64   8'h3f
`define PTMR_PRE_TERM_DIV256  8'hff

`endif

// ---- shared/ptmr_pkg.sv ----
// Types of the paired timer: prescale selection and the module's state record.
// Assumes ptmr_regs.svh is on the include path.
`include "ptmr_regs.svh"

package ptmr_pkg;

  // ****************************************
  // Prescale selection
  // ****************************************
  typedef enum logic [1:0] {
    PTMR_DIV1   = 2'h0,
    PTMR_DIV8   = 2'h1,
    PTMR_DIV64  = 2'h2,
    PTMR_DIV256 = 2'h3
  } ptmr_presc_t;

  // ****************************************
  // Whole state of the timer pair
  // ****************************************
  typedef struct packed {
    logic [15:0] lowCount;
    logic [15:0] highCount;
    logic [15:0] holding;
    logic [15:0] periodLow;
    logic [15:0] periodHigh;
    logic [15:0] lowCtrl;
    logic [15:0] highCtrl;
    logic [7:0]  preLow;
    logic [7:0]  preHigh;
    logic        lowTickSync;
    logic [1:0]  gateSync;
    logic [1:0]  highSync;
    logic        gateDly;
    logic        highDly;
    logic        lowFlag;
    logic        highFlag;
    logic        lowIrq;
    logic        highIrq;
    logic        adcTrig;
  } ptmr_state_t;

endpackage : ptmr_pkg

// ---- bench/ptmr_pin_source.sv ----
// Far-side source for the timer pins: external clock pulses and gate windows.
// Assumes it is driven from the bench clock; pins idle low between frames.
`timescale 1ns/1ps

module ptmr_pin_source (
  // Clock
  input  wire logic clk,
  // Pins toward the timer
  output logic      gatePin,
  output logic      highPin
);
  // ****************************************
  // Pin stimulus
  // ****************************************
  initial begin
    gatePin = 1'b0;
    highPin = 1'b0;
  end

  // Square pulses; a long half period models a slow source
  task automatic pulses(input int n, input int half, input bit toHigh);
    for (int i = 0; i < n; i++) begin
      repeat (half) @(posedge clk);
      if (toHigh) highPin <= 1'b1;
      else gatePin <= 1'b1;
      repeat (half) @(posedge clk);
      highPin <= 1'b0;
      gatePin <= 1'b0;
    end
  endtask : pulses

  // Gate window of len cycles, ended by a falling edge
  task automatic gate(input int len);
    @(posedge clk);
    gatePin <= 1'b1;
    repeat (len) @(posedge clk);
    gatePin <= 1'b0;
  endtask : gate
endmodule : ptmr_pin_source

// ---- bench/ptmr_paired_timer_sva.sv ----
// Port-level checker of the paired timer.
// Assumes the port names of ptmr_paired_timer; attached by the bind at the foot.
`timescale 1ns/1ps

module ptmr_paired_timer_sva (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Inputs watched
  input wire logic        clkEn,
  input wire logic        cpuIdle,
  input wire logic        cpuSleep,
  input wire logic [15:0] wrData,
  input wire logic        wrLowCount,
  input wire logic        wrHighCount,
  input wire logic        wrHolding,
  input wire logic        wrLowCtrl,
  input wire logic        rdLowCount,
  input wire logic        highTimerIntEnable,
  input wire logic        clrHighIntFlag,
  // Outputs watched
  input wire logic [15:0] lowCountWord,
  input wire logic [15:0] highCountWord,
  input wire logic [15:0] highWordHolding,
  input wire logic [15:0] periodLow,
  input wire logic [15:0] lowTimerControl,
  input wire logic        highTimerIntFlag,
  input wire logic        highIntReq,
  input wire logic        adcTrigger
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Three or four quiet cycles drain the synchroniser pipeline first
  sequence s_asleep; cpuSleep [*4] ##0 (!wrLowCount && !wrHighCount); endsequence
  sequence s_idled; (cpuIdle && lowTimerControl[13]) [*4] ##0 !wrLowCount; endsequence
  sequence s_offCtrl; !lowTimerControl[15] [*3] ##0 (clkEn && wrLowCtrl && !wrLowCount && !wrHighCount); endsequence

  property p_sleep; s_asleep |=> $stable(lowCountWord) && $stable(highCountWord); endproperty
  property p_idle; s_idled |=> $stable(lowCountWord); endproperty
  property p_ctrlKeep; s_offCtrl |=> $stable(lowCountWord); endproperty
  property p_write; clkEn && wrLowCount |=> lowCountWord == $past(wrData); endproperty
  property p_chainLoad;
    clkEn && wrLowCount && lowTimerControl[3] && !wrHighCount |=> highCountWord == $past(highWordHolding);
  endproperty
  property p_readLatch; clkEn && rdLowCount && !wrHolding |=> highWordHolding == $past(highCountWord); endproperty
  property p_wrap;
    lowCountWord != $past(lowCountWord) && !$past(wrLowCount) && !$past(lowTimerControl[3]) && !lowTimerControl[3]
      |-> lowCountWord == (($past(lowCountWord) == $past(periodLow)) ? 16'h0000 : $past(lowCountWord) + 16'h0001);
  endproperty
  property p_req; $past(clkEn) |-> highIntReq == (highTimerIntFlag && $past(highTimerIntEnable)); endproperty
  property p_sticky; highTimerIntFlag && !(clkEn && clrHighIntFlag) |=> highTimerIntFlag; endproperty
  property p_trig;
    $rose(adcTrigger) && !$past(wrHighCount) && !$past(wrLowCount) |-> highCountWord == 16'h0000;
  endproperty

  a_sleep: assert property (p_sleep) else $error("count moved in sleep");
  a_idle: assert property (p_idle) else $error("count moved in idle");
  a_ctrlKeep: assert property (p_ctrlKeep) else $error("control write changed count");
  a_write: assert property (p_write) else $error("low count write lost");
  a_chainLoad: assert property (p_chainLoad) else $error("holding not moved to high count");
  a_readLatch: assert property (p_readLatch) else $error("holding not latched on read");
  a_wrap: assert property (p_wrap) else $error("low count step wrong");
  a_req: assert property (p_req) else $error("high request not flag and enable");
  a_sticky: assert property (p_sticky) else $error("high flag cleared by itself");
  a_trig: assert property (p_trig) else $error("trigger without high match");
endmodule : ptmr_paired_timer_sva

bind ptmr_paired_timer ptmr_paired_timer_sva u_sva (.clk, .resetn, .clkEn, .cpuIdle, .cpuSleep, .wrData,
  .wrLowCount, .wrHighCount, .wrHolding, .wrLowCtrl, .rdLowCount, .highTimerIntEnable, .clrHighIntFlag,
  .lowCountWord, .highCountWord, .highWordHolding, .periodLow, .lowTimerControl, .highTimerIntFlag,
  .highIntReq, .adcTrigger);

// ---- bench/test_paired_timer_32bit.sv ----
// Self-checking bench of the paired timer, one task per scenario.
// Assumes the design, its checker and the pin source are compiled first.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin failures++; $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end

module test_paired_timer_32bit;
  // ****************************************
  // Stimulus and observation
  // ****************************************
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        clkEn = 1'b1;
  logic        cpuIdle = 1'b0;
  logic        cpuSleep = 1'b0;
  logic [15:0] wrData = 16'h0000;
  logic [9:0]  stb = 10'h000;
  logic [1:0]  intEn = 2'h0;
  logic        gatePin, highPin, lowFlag, highFlag, lowReq, highReq, trig;
  logic [15:0] lowCnt, highCnt, hold, perLow, perHigh, ctlLow, ctlHigh;
  int          failures = 0;
  int          checked = 0;
  int          cycles = 0;
  int          divs[4] = '{1, 8, 64, 256};

  always #2.5 clk = ~clk;

  ptmr_pin_source src (.clk(clk), .gatePin(gatePin), .highPin(highPin));

  // Strobe bits: counts, holding, periods, controls, read, flag clears
  ptmr_paired_timer uut (.clk(clk), .resetn(resetn), .clkEn(clkEn), .cpuIdle(cpuIdle), .cpuSleep(cpuSleep),
    .gateClockInput(gatePin), .highClockInput(highPin), .wrData(wrData), .wrLowCount(stb[0]),
    .wrHighCount(stb[1]), .wrHolding(stb[2]), .wrPeriodLow(stb[3]), .wrPeriodHigh(stb[4]),
    .wrLowCtrl(stb[5]), .wrHighCtrl(stb[6]), .rdLowCount(stb[7]), .lowIntEnable(intEn[0]),
    .highTimerIntEnable(intEn[1]), .clrLowIntFlag(stb[8]), .clrHighIntFlag(stb[9]),
    .lowCountWord(lowCnt), .highCountWord(highCnt), .highWordHolding(hold), .periodLow(perLow),
    .periodHigh(perHigh), .lowTimerControl(ctlLow), .highTimerControl(ctlHigh), .lowIntFlag(lowFlag),
    .highTimerIntFlag(highFlag), .lowIntReq(lowReq), .highIntReq(highReq), .adcTrigger(trig));

  // One-cycle strobe with data; a gap cycle keeps strobes apart
  task automatic wr(input int sel, input logic [15:0] d);
    @(posedge clk);
    stb <= 10'h001 << sel;
    wrData <= d;
    @(posedge clk);
    stb <= 10'h000;
    @(negedge clk);
  endtask : wr

  // Wait for a flag (0 low flag, 1 trigger, 2 high flag), sampled mid-cycle
  task automatic waitHigh(input int which, input int lim);
    logic s;
    s = (which == 0) ? lowFlag : ((which == 1) ? trig : highFlag);
    for (int n = 0; n < lim && s !== 1'b1; n++) begin
      @(negedge clk);
      s = (which == 0) ? lowFlag : ((which == 1) ? trig : highFlag);
    end
    `CHK("waitHigh", 1'b1, s)
  endtask : waitHigh

  // Cycles until the low count next moves
  task automatic gap(output int n);
    logic [15:0] v;
    v = lowCnt;
    for (n = 0; n < 600 && lowCnt === v; n++) @(negedge clk);
  endtask : gap

  task automatic settle(input int n, input logic [15:0] ex, input bit hi);
    repeat (n) @(negedge clk);
    `CHK("count", ex, (hi ? highCnt : lowCnt))
  endtask : settle

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    @(negedge clk);
    `CHK("periods", 32'hffffffff, {perHigh, perLow})
    `CHK("controls", 32'h0, {ctlHigh, ctlLow})
    `CHK("count32", 32'h0, {highCnt, lowCnt})
  endtask : t_reset

  task automatic t_prescale;
    int n;
    for (int c = 0; c < 4; c++) begin
      wr(5, 16'h8000 | 16'(c << 4));
      gap(n);
      gap(n);
      `CHK("tickGap", divs[c], n)
    end
  endtask : t_prescale

  task automatic t_timer16;
    wr(5, 16'h8000);
    wr(3, 16'h0003);
    @(posedge clk) intEn <= 2'h3;
    wr(0, 16'h0000);
    waitHigh(0, 20);
    `CHK("lowWrap", 16'h0000, lowCnt)
    `CHK("lowReq", 1'b1, lowReq)
    wr(4, 16'h0002);
    wr(6, 16'h8000);
    waitHigh(1, 20);
    `CHK("highWrap", 16'h0000, highCnt)
    wr(6, 16'h0000);
  endtask : t_timer16

  task automatic t_chain32;
    wr(6, 16'h0030); // high control must be ignored
    wr(3, 16'h0001);
    wr(4, 16'h0002);
    wr(5, 16'h0008); // chained but stopped while loading
    wr(2, 16'h0001);
    wr(0, 16'hfffd);
    `CHK("highLoad", 16'h0001, highCnt)
    `CHK("lowLoad", 16'hfffd, lowCnt)
    wr(2, 16'h0005);
    wr(7, 16'h0000);
    `CHK("holding", 16'h0001, hold)
    wr(9, 16'h0000);
    wr(5, 16'h8008);
    waitHigh(2, 20);
    `CHK("wrap32", 32'h0, {highCnt, lowCnt})
    `CHK("highReq", 1'b1, highReq)
    wr(5, 16'h0000);
    `CHK("flagKept", 1'b1, highFlag)
    wr(9, 16'h0000);
    `CHK("flagClear", 1'b0, highFlag)
  endtask : t_chain32

  task automatic t_gate;
    wr(3, 16'hffff);
    wr(8, 16'h0000);
    wr(5, 16'h8040);
    wr(0, 16'h0000);
    src.gate(10);
    settle(8, 16'h000a, 1'b0);
    `CHK("gateFlag", 1'b1, lowFlag)
    wr(0, 16'h0000);
    `CHK("gateClr", 16'h0000, lowCnt)
  endtask : t_gate

  task automatic t_counter;
    wr(5, 16'ha002);
    wr(0, 16'h0000);
    src.pulses(4, 2, 1'b0);
    src.pulses(2, 30, 1'b0);
    settle(8, 16'h0006, 1'b0);
    @(posedge clk) cpuIdle <= 1'b1;
    src.pulses(3, 2, 1'b0);
    settle(8, 16'h0006, 1'b0);
    @(posedge clk) cpuIdle <= 1'b0;
    cpuSleep <= 1'b1;
    src.pulses(3, 2, 1'b0);
    settle(8, 16'h0006, 1'b0);
    @(posedge clk) cpuSleep <= 1'b0;
    src.pulses(1, 2, 1'b0);
    settle(8, 16'h0007, 1'b0);
    wr(5, 16'h0000);
    `CHK("ctrlKeep", 16'h0007, lowCnt)
    wr(1, 16'h0000);
    wr(6, 16'h8002);
    src.pulses(2, 2, 1'b1);
    settle(8, 16'h0002, 1'b1);
  endtask : t_counter

  // ****************************************
  // Run control
  // ****************************************
  task automatic finish_test;
    $display("Checks %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  // Ceiling well above the roughly one thousand cycles the scenarios need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_prescale();
    t_timer16();
    t_chain32();
    t_gate();
    t_counter();
    finish_test();
  end
endmodule : test_paired_timer_32bit
